// ### aperture_delay_adjust_control.sv
// Aperture delay adjust control: calibration status, manual delay register,
// coarse ramp control and the applied sample-clock delay setting.
// Assumes a serial-port front end that issues byte reads and writes on this
// clock, and a calibration engine that reports completion and its result.
`timescale 1ns/1ps
`default_nettype none

`include "aperture_delay_regs.svh"

// Overview of operation
// - Read-only status register reports completion and computed delay.
// - Flag bit 17 reads 1 only while enabled and calibration finished.
// - Calibrated 17-bit result is valid only while the flag reads 1.
// - Result bit 16 is clock inversion, 15:8 coarse, 7:0 fine delay.
// - Manual register sets the delay only while calibration is disabled.
// - Manual bit 16 inverts clock, 15:8 coarse, 7:0 fine delay.
// - Fine delay may change to any value at any time.
// - A 0-to-1 enable starts calibration; then manual delay is ignored.
// - With ramp on, coarse steps one or four codes every 256 cycles.
// - With ramp off, a written coarse delay applies within 1024 cycles.
module aperture_delay_adjust_control
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire aperture_delay_pkg::reg_req_s i_reg_req,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_cal_done,
  input wire aperture_delay_pkg::delay_s i_cal_result,
  output logic o_cal_start,
  output logic o_calibration_enable,
  output aperture_delay_pkg::delay_s o_aperture_delay_setting
);
  import aperture_delay_pkg::*;

  logic cal_en_r;
  logic ramp_en_r;
  logic ramp_rate_r;
  logic cal_start_r;
  logic done_r;
  delay_s result_r;
  delay_s manual_r;
  delay_s target;
  delay_s applied_r;
  logic [7:0] coarse_now;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic [23:0] status_word;
  logic [23:0] manual_word;
  logic wr_cal;
  logic wr_manual;
  logic wr_ramp;
  logic [1:0] manual_idx;
  logic [1:0] status_idx;
  logic flag_live;

  // The 24-bit registers are decoded as three-byte windows for reads; only
  // the manual register is also decoded that way for writes.
  function automatic logic in_window(input reg_addr_t addr,
                                     input reg_addr_t base);
    in_window = (addr >= base) && (addr < base + 12'(`ADA_REG_BYTES));
  endfunction

  function automatic logic [1:0] byte_index(input reg_addr_t addr,
                                            input reg_addr_t base);
    byte_index = 2'(addr - base);
  endfunction

  assign manual_idx = byte_index(i_reg_req.addr, `ADA_OFS_MANUAL);
  assign status_idx = byte_index(i_reg_req.addr, `ADA_OFS_STATUS);
  assign wr_cal = i_reg_req.wr && i_reg_req.addr == `ADA_OFS_CAL_EN;
  assign wr_ramp = i_reg_req.wr && i_reg_req.addr == `ADA_OFS_RAMP;
  assign wr_manual = i_reg_req.wr &&
                     in_window(i_reg_req.addr, `ADA_OFS_MANUAL);

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cal_en_r <= 1'b0;
      cal_start_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      cal_start_r <= 1'b0;
      if (wr_cal)
      begin
        cal_en_r <= i_reg_req.wdata[`ADA_CAL_EN_BIT];
        // Only a rising edge launches a new sequence.
        cal_start_r <= i_reg_req.wdata[`ADA_CAL_EN_BIT] &&
                       !cal_en_r;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ramp_en_r <= 1'b0;
      ramp_rate_r <= 1'b0;
    end
    else if (i_clk_en && wr_ramp)
    begin
      ramp_en_r <= i_reg_req.wdata[`ADA_RAMP_EN_BIT];
      ramp_rate_r <= i_reg_req.wdata[`ADA_RAMP_RATE_BIT];
    end
  end

  // Completion is cleared by a new start or by disabling calibration; a
  // completion arriving with a new start still wins, but one arriving while disabled is dropped.
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      done_r <= 1'b0;
      result_r <= '0;
    end
    else if (i_clk_en)
    begin
      if (cal_en_r && i_cal_done)
      begin
        done_r <= 1'b1;
        result_r <= i_cal_result;
      end
      else if (cal_start_r || !cal_en_r)
        done_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      manual_r <= `ADA_MANUAL_RST;
    else if (i_clk_en && wr_manual)
    begin
      // Bits above the inversion bit are reserved and not stored.
      case (manual_idx)
        2'h0: manual_r.invert <= i_reg_req.wdata[0];
        2'h1: manual_r.coarse <= i_reg_req.wdata;
        default: manual_r.fine <= i_reg_req.wdata;
      endcase
    end
  end

  // While calibrating, the last applied setting is held until a result is
  // ready, so the clock does not jump back to the manual value.
  always_comb
  begin
    if (!cal_en_r)
      target = manual_r;
    else if (done_r)
      target = result_r;
    else
      target = applied_r;
  end

  coarse_ramp_stepper u_stepper
  (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_target(target.coarse),
    .i_ramp_en(ramp_en_r),
    .i_ramp_rate(ramp_rate_r),
    .o_coarse(coarse_now)
  );

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      applied_r <= `ADA_MANUAL_RST;
    else if (i_clk_en)
    begin
      // Inversion and fine delay apply at once; the coarse delay is paced.
      applied_r.invert <= target.invert;
      applied_r.fine <= target.fine;
      applied_r.coarse <= coarse_now;
    end
  end

  // The stored flag clears one cycle after the enable drops, so it is
  // masked here to read 0 as soon as calibration is disabled.
  assign flag_live = done_r && cal_en_r;
  assign status_word = {6'h00, flag_live, result_r};
  assign manual_word = {7'h00, manual_r};

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      rvalid_r <= i_reg_req.rd;
      if (!i_reg_req.rd)
        rdata_r <= rdata_r;
      else if (i_reg_req.addr == `ADA_OFS_CAL_EN)
        rdata_r <= {7'h00, cal_en_r};
      else if (in_window(i_reg_req.addr, `ADA_OFS_STATUS))
        rdata_r <= reg_byte(status_word, status_idx);
      else if (in_window(i_reg_req.addr, `ADA_OFS_MANUAL))
        rdata_r <= reg_byte(manual_word, manual_idx);
      else if (i_reg_req.addr == `ADA_OFS_RAMP)
        rdata_r <= {6'h00, ramp_rate_r, ramp_en_r};
      else
        rdata_r <= 8'h00;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_reg_rvalid = rvalid_r;
  assign o_cal_start = cal_start_r;
  assign o_calibration_enable = cal_en_r;
  assign o_aperture_delay_setting = applied_r;

endmodule // aperture_delay_adjust_control

`default_nettype wire

// ### aperture_delay_regs.svh
// Register offsets, field positions, reset values and timing counts for the
// aperture delay adjust control block.
// Assumes byte-wide register access from the serial configuration port.
`ifndef APERTURE_DELAY_REGS_SVH
`define APERTURE_DELAY_REGS_SVH

`define ADA_ADDR_W 12
`define ADA_OFS_CAL_EN 12'h2b0
`define ADA_OFS_STATUS 12'h2b2
`define ADA_OFS_MANUAL 12'h2b5
`define ADA_OFS_RAMP 12'h2b8
`define ADA_REG_BYTES 2'h3

`define ADA_DONE_BIT 17
`define ADA_INV_BIT 16
`define ADA_COARSE_MSB 15
`define ADA_COARSE_LSB 8
`define ADA_FINE_MSB 7
`define ADA_FINE_LSB 0
`define ADA_RAMP_EN_BIT 0
`define ADA_RAMP_RATE_BIT 1
`define ADA_CAL_EN_BIT 0

`define ADA_MANUAL_RST 17'h00000
`define ADA_CTRL_RST 8'h00

`define ADA_RAMP_INTERVAL 256
`define ADA_RAMP_STEP_SLOW 8'h01
`define ADA_RAMP_STEP_FAST 8'h04
`define ADA_APPLY_LIMIT 1024

`endif

// ### aperture_delay_pkg.sv
// Types shared by the aperture delay adjust control block.
// Assumes aperture_delay_regs.svh is on the include path.
`default_nettype none
`include "aperture_delay_regs.svh"

package aperture_delay_pkg;

  typedef logic [`ADA_ADDR_W-1:0] reg_addr_t;

  typedef struct packed
  {
    logic invert;
    logic [7:0] coarse;
    logic [7:0] fine;
  } delay_s;

  typedef struct packed
  {
    reg_addr_t addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_s;

  function automatic logic [7:0] reg_byte(input logic [23:0] word,
                                          input logic [1:0] idx);
    // Lowest address carries the most significant byte.
    case (idx)
      2'h0: reg_byte = word[23:16];
      2'h1: reg_byte = word[15:8];
      default: reg_byte = word[7:0];
    endcase
  endfunction

endpackage

`default_nettype wire

// ### coarse_ramp_stepper.sv
// Coarse delay stepper: moves the applied coarse delay toward its target.
// Assumes target, ramp enable and rate come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module coarse_ramp_stepper
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic [7:0] i_target,
  input wire logic i_ramp_en,
  input wire logic i_ramp_rate,
  output logic [7:0] o_coarse
);

  logic [7:0] coarse_r;
  logic [7:0] tick_r;
  logic [7:0] step;
  logic [7:0] diff;
  logic tick_due;

  assign tick_due = (tick_r == 8'(`ADA_RAMP_INTERVAL - 1));
  assign step = i_ramp_rate ? `ADA_RAMP_STEP_FAST : `ADA_RAMP_STEP_SLOW;
  assign diff = (i_target > coarse_r) ? (i_target - coarse_r)
                                      : (coarse_r - i_target);

  // The interval timer free-runs so steps land at least 256 cycles apart.
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      tick_r <= 8'h00;
    else if (i_clk_en)
      tick_r <= tick_r + 8'h01;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      coarse_r <= 8'h00;
    else if (i_clk_en)
    begin
      if (!i_ramp_en)
        coarse_r <= i_target;
      else if (tick_due && coarse_r != i_target)
      begin
        // The last step is clipped so the ramp never overshoots the target.
        if (diff <= step)
          coarse_r <= i_target;
        else if (i_target > coarse_r)
          coarse_r <= coarse_r + step;
        else
          coarse_r <= coarse_r - step;
      end
    end
  end

  assign o_coarse = coarse_r;

endmodule // coarse_ramp_stepper

`default_nettype wire

// ### aperture_delay_monitor.sv
// Checker for the aperture delay block, bound to its top ports.
// Assumes one clock domain with the clock enable held high.
`timescale 1ns/1ps
`default_nettype none
module aperture_delay_monitor
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire aperture_delay_pkg::reg_req_s i_reg_req,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic i_cal_done,
  input wire aperture_delay_pkg::delay_s i_cal_result,
  input wire logic o_cal_start,
  input wire logic o_calibration_enable,
  input wire aperture_delay_pkg::delay_s o_aperture_delay_setting
);
  import aperture_delay_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  read_answer_a: assert property
    (i_reg_req.rd && i_clk_en |=> o_reg_rvalid) else $error("no answer");
  start_edge_a: assert property
    (o_cal_start == $rose(o_calibration_enable)) else $error("bad start");
  status_top_a: assert property
    (o_reg_rvalid && $past(i_reg_req.addr) == 12'h2b2 |-> o_reg_rdata[7:2]
    == 6'h00 && (!o_reg_rdata[1] || o_calibration_enable)) else $error("flag");
  manual_top_a: assert property
    (o_reg_rvalid && $past(i_reg_req.addr) == 12'h2b5 |->
    o_reg_rdata[7:1] == 7'h00) else $error("manual top byte");
  fine_apply_a: assert property
    (i_clk_en && i_reg_req.wr && i_reg_req.addr == 12'h2b7 &&
    !o_calibration_enable |->
    ##2 o_aperture_delay_setting.fine == $past(i_reg_req.wdata, 2))
    else $error("fine not applied");
  invert_apply_a: assert property
    (i_clk_en && i_reg_req.wr && i_reg_req.addr == 12'h2b5 &&
    !o_calibration_enable |->
    ##2 o_aperture_delay_setting.invert == $past(i_reg_req.wdata[0], 2))
    else $error("invert not applied");
  result_apply_a: assert property
    (i_clk_en && o_calibration_enable && i_cal_done |->
    ##2 o_aperture_delay_setting.fine == $past(i_cal_result.fine, 2))
    else $error("result not applied");
  cal_hold_a: assert property
    (o_cal_start && !i_cal_done |=> $stable(o_aperture_delay_setting))
    else $error("setting moved");
endmodule // aperture_delay_monitor
bind aperture_delay_adjust_control aperture_delay_monitor u_mon
(
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_clk_en(i_clk_en),
  .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .i_cal_done(i_cal_done),
  .i_cal_result(i_cal_result), .o_cal_start(o_cal_start),
  .o_calibration_enable(o_calibration_enable),
  .o_aperture_delay_setting(o_aperture_delay_setting)
);
`default_nettype wire

// ### tb.sv
// Testbench: byte register accesses with expected values.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import aperture_delay_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  reg_req_s req = '0;
  logic done = 1'b0;
  delay_s res = '0;
  logic [7:0] rdata;
  logic rvalid, start, cen;
  delay_s set;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  aperture_delay_adjust_control u_dut
  (
    .i_core_clk(clk), .i_resetn(rstn), .i_clk_en(ce), .i_reg_req(req),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_cal_done(done),
    .i_cal_result(res), .o_cal_start(start),
    .o_calibration_enable(cen), .o_aperture_delay_setting(set)
  );
  task automatic chk(input logic [16:0] got, exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk({8'h00, rvalid, rdata}, {9'h001, e}, "read byte");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(12'h2b5, 8'h00);
    rd(12'h2b7, 8'h00);
    rd(12'h2b2, 8'h00);
    rd(12'h2c0, 8'h00);
    wr(12'h2b4, 8'hff);
    rd(12'h2b4, 8'h00);
    wr(12'h2b5, 8'hff);
    wr(12'h2b6, 8'h40);
    wr(12'h2b7, 8'h5a);
    rd(12'h2b5, 8'h01);
    tick(3);
    chk(set, 17'h1405a, "manual");
    // Slow ramp: the free timer allows at most one step in 100 cycles.
    wr(12'h2b8, 8'h01);
    wr(12'h2b6, 8'h44);
    tick(100);
    chk({16'h0, set.coarse <= 8'h41}, 17'h1, "slow step");
    tick(1030);
    chk(set, 17'h1445a, "slow end");
    wr(12'h2b8, 8'h03);
    rd(12'h2b8, 8'h03);
    wr(12'h2b6, 8'h4c);
    tick(200);
    chk({16'h0, set.coarse <= 8'h48}, 17'h1, "fast step");
    tick(330);
    chk(set, 17'h14c5a, "fast end");
    wr(12'h2b8, 8'h00);
    wr(12'h2b0, 8'h01);
    chk({16'h0, start}, 17'h1, "start");
    chk({16'h0, cen}, 17'h1, "enable level");
    rd(12'h2b0, 8'h01);
    rd(12'h2b2, 8'h00);
    @(posedge clk);
    done <= 1'b1;
    res <= '{1'b1, 8'h22, 8'h33};
    @(posedge clk);
    done <= 1'b0;
    tick(4);
    chk(set, 17'h12233, "result");
    rd(12'h2b2, 8'h03);
    rd(12'h2b3, 8'h22);
    rd(12'h2b4, 8'h33);
    wr(12'h2b7, 8'h00);
    tick(4);
    chk(set, 17'h12233, "manual ignored");
    wr(12'h2b0, 8'h00);
    tick(4);
    chk(set, 17'h14c00, "manual again");
    rd(12'h2b2, 8'h01);
    wr(12'h2b5, 8'h01);
    wr(12'h2b6, 8'h22);
    wr(12'h2b7, 8'h33);
    tick(4);
    chk(set, 17'h12233, "restored");
    wr(12'h2b6, 8'h26);
    tick(4);
    chk(set, 17'h12633, "small step");
    // A write made while the clock enable is low must not be taken.
    @(posedge clk);
    ce <= 1'b0;
    wr(12'h2b7, 8'h77);
    @(posedge clk);
    ce <= 1'b1;
    rd(12'h2b7, 8'h33);
    chk(set, 17'h12633, "frozen");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    chk(set, 17'h00000, "reset value");
    rstn <= 1'b1;
    rd(12'h2b6, 8'h00);
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
